//--- bench/ddrpi_mem_model.sv
// behavioural ddr memory on the far side of the pin interface, one 4-word burst store
// assumes the bench resolves the two-way data and strobe wires from the enables
`timescale 1ns/1ps
module ddrpi_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_link_clk,
  input  wire logic [13:0] i_addr,
  input  wire logic [1:0]  i_bank,
  input  wire logic        i_row_strobe_n,
  input  wire logic        i_col_strobe_n,
  input  wire logic        i_write_en_n,
  input  wire logic [1:0]  i_chip_sel_n,
  input  wire logic [31:0] i_data,
  input  wire logic [7:0]  i_mask,
  input  wire logic [3:0]  i_strobe,
  input  wire logic        i_data_oe_n,
  output logic      [31:0] o_data,
  output logic      [3:0]  o_strobe
);
  logic [31:0] mem [4];
  logic [13:0] act_row;
  logic [13:0] rw_col;
  logic [1:0]  act_bank;
  logic [1:0]  rw_bank;
  logic [1:0]  sel_n;
  logic        rw_we_n;
  logic [7:0]  last_mask;
  logic [3:0]  strobe_q;
  int          wcount;
  wire         sel = i_chip_sel_n != 2'h3;

  initial begin
    for (int k = 0; k < 4; k++) mem[k] = 32'h0;
    wcount = 0;
    strobe_q = 4'h0;
    o_data = 32'h0;
    o_strobe = 4'h0;
  end

  always @(posedge i_clk) begin
    if (sel && !i_row_strobe_n && i_col_strobe_n) begin
      act_row <= i_addr;
      act_bank <= i_bank;
      sel_n <= i_chip_sel_n;
    end
    if (sel && i_row_strobe_n && !i_col_strobe_n) begin
      rw_col <= i_addr;
      rw_bank <= i_bank;
      rw_we_n <= i_write_en_n;
    end
    strobe_q <= i_strobe;
    // write word taken on each strobe edge, masked bytes kept
    if (!i_data_oe_n && i_strobe[0] != strobe_q[0]) begin
      for (int n = 0; n < 4; n++) begin
        if (!i_mask[n]) mem[wcount[1:0]][8*n+:8] <= i_data[8*n+:8];
      end
      last_mask <= i_mask;
      wcount <= wcount + 1;
    end
  end

  // read burst: data at each link edge, strobe a quarter period later
  always @(negedge i_link_clk) begin
    if (sel && i_row_strobe_n && !i_col_strobe_n && i_write_en_n) begin
      for (int k = 0; k < 4; k++) begin
        o_data = mem[k];
        #40 o_strobe = ~o_strobe;
        #40;
      end
      o_data = ~o_data;
    end
  end
endmodule

//--- bench/tb.sv
// testbench for the ddr pin interface: row table, fifo fill, power-down, reset
// assumes the package and the memory model are compiled before it
`timescale 1ns/1ps
`include "ddrpi_consts.svh"
module tb;
  typedef struct packed {
    ddrpi_pkg::ddrpi_cmd_s cmd;
    logic [31:0]           base;
    logic [7:0]            ben;
    logic [1:0]            cs_n;
  } ddrpi_row_s;

  logic                  i_clk = 1'b0;
  logic                  i_rst_b = 1'b0;
  logic                  i_link_clk = 1'b0;
  logic                  i_pwr_down = 1'b0;
  logic                  i_cmd_valid = 1'b0;
  ddrpi_pkg::ddrpi_cmd_s i_cmd = '0;
  logic                  i_wr_valid = 1'b0;
  ddrpi_pkg::ddrpi_wr_s  i_wr = '0;
  logic                  o_cmd_ready, o_wr_ready, o_rd_valid;
  logic [31:0]           o_rd_data, o_mem_data_bus, m_data, dq;
  logic [13:0]           o_mem_row_col_addr;
  logic [1:0]            o_mem_bank_sel, o_mem_clk_pos, o_mem_clk_neg, o_mem_chip_sel_n;
  logic                  o_mem_row_strobe_n, o_mem_col_strobe_n, o_mem_write_en_n;
  logic                  o_mem_clk_en, o_mem_data_bus_oe_n, o_mem_byte_strobe_oe_n;
  logic [7:0]            o_mem_byte_mask;
  logic [3:0]            o_mem_byte_strobe, m_strobe, dqs, o_mem_switch_oe_n;
  ddrpi_row_s            rows [6];
  logic [31:0]           exp_mem [4];
  logic [31:0]           rd_q [$];
  logic [31:0]           d;
  logic                  rd_pend = 1'b0;
  int                    bad_count = 0;
  int                    checks_done = 0;
  int                    wc, n;

  assign dq  = o_mem_data_bus_oe_n ? m_data : o_mem_data_bus;
  assign dqs = o_mem_byte_strobe_oe_n ? m_strobe : o_mem_byte_strobe;

  ddrpi_top ddrpi_top_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_link_clk(i_link_clk),
    .i_pwr_down(i_pwr_down), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready), .i_wr_valid(i_wr_valid), .i_wr(i_wr),
    .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_mem_row_col_addr(o_mem_row_col_addr), .o_mem_bank_sel(o_mem_bank_sel),
    .o_mem_row_strobe_n(o_mem_row_strobe_n), .o_mem_col_strobe_n(o_mem_col_strobe_n),
    .o_mem_write_en_n(o_mem_write_en_n), .o_mem_clk_en(o_mem_clk_en),
    .o_mem_clk_pos(o_mem_clk_pos), .o_mem_clk_neg(o_mem_clk_neg),
    .o_mem_chip_sel_n(o_mem_chip_sel_n), .i_mem_data_bus(dq),
    .o_mem_data_bus(o_mem_data_bus), .o_mem_data_bus_oe_n(o_mem_data_bus_oe_n),
    .o_mem_byte_mask(o_mem_byte_mask), .i_mem_byte_strobe(dqs),
    .o_mem_byte_strobe(o_mem_byte_strobe), .o_mem_byte_strobe_oe_n(o_mem_byte_strobe_oe_n),
    .o_mem_switch_oe_n(o_mem_switch_oe_n));

  ddrpi_mem_model ddrpi_mem_model_inst (.i_clk(i_clk), .i_link_clk(i_link_clk),
    .i_addr(o_mem_row_col_addr), .i_bank(o_mem_bank_sel),
    .i_row_strobe_n(o_mem_row_strobe_n), .i_col_strobe_n(o_mem_col_strobe_n),
    .i_write_en_n(o_mem_write_en_n), .i_chip_sel_n(o_mem_chip_sel_n), .i_data(dq),
    .i_mask(o_mem_byte_mask), .i_strobe(dqs), .i_data_oe_n(o_mem_data_bus_oe_n),
    .o_data(m_data), .o_strobe(m_strobe));

  always #5 i_clk = ~i_clk;
  initial begin
    #37;
    forever #80 i_link_clk = ~i_link_clk;
  end

  task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (exp !== got) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic cond(int w);
    case (w)
      0: return o_cmd_ready;
      1: return !o_mem_clk_en;
      2: return o_mem_clk_en;
      3: return !o_mem_data_bus_oe_n;
      default: return o_wr_ready;
    endcase
  endfunction

  task automatic wait_cond(int w, int lim);
    int k;
    k = 0;
    while (cond(w) !== 1'b1 && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    if (cond(w) !== 1'b1) begin
      chk("wait bound", 1, 0);
      finish_test();
    end
  endtask

  task automatic push(logic [31:0] dat, logic [7:0] be);
    @(negedge i_clk);
    i_wr = {dat, be};
    i_wr_valid = 1'b1;
    wait_cond(4, 500);
    @(negedge i_clk);
    i_wr_valid = 1'b0;
  endtask

  task automatic send_cmd(ddrpi_pkg::ddrpi_cmd_s c);
    @(negedge i_clk);
    i_cmd = c;
    i_cmd_valid = 1'b1;
    wait_cond(0, 500);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    wait_cond(0, 500);
  endtask

  task automatic chk_reset();
    chk("reset pins", {1'b0, 2'h3, 3'h7, 1'b1, 8'hFF, 4'hF, 2'h0}, {o_mem_clk_en,
      o_mem_chip_sel_n, o_mem_row_strobe_n, o_mem_col_strobe_n, o_mem_write_en_n,
      o_mem_data_bus_oe_n, o_mem_byte_mask, o_mem_switch_oe_n, o_cmd_ready, o_wr_ready});
  endtask

  // read words land one cycle after the lane-0 pulse
  always @(negedge i_clk) begin
    if (rd_pend) rd_q.push_back(o_rd_data);
    rd_pend = o_rd_valid;
    if (i_rst_b) begin
      chk("clk pair", 2'(~o_mem_clk_pos), o_mem_clk_neg);
      chk("clk copies", o_mem_clk_pos[0], o_mem_clk_pos[1]);
      if (!o_mem_data_bus_oe_n) chk("switch oe", 4'h0, o_mem_switch_oe_n);
    end
  end

  initial begin
    for (int k = 0; k < 4; k++) exp_mem[k] = 32'h0;
    rows[0] = {1'b1, 1'b0, 2'h0, 14'h0001, 14'h0002, 32'hA0A0_0000, 8'hFF, 2'h2};
    rows[1] = {1'b0, 1'b0, 2'h0, 14'h0001, 14'h0002, 32'h0, 8'h00, 2'h2};
    rows[2] = {1'b1, 1'b1, 2'h3, 14'h3FFF, 14'h3FFF, 32'h5500_0010, 8'hA5, 2'h1};
    rows[3] = {1'b0, 1'b1, 2'h3, 14'h3FFF, 14'h3FFF, 32'h0, 8'h00, 2'h1};
    rows[4] = {1'b1, 1'b0, 2'h1, 14'h2AAA, 14'h1555, 32'h1234_5600, 8'h0F, 2'h2};
    rows[5] = {1'b0, 1'b1, 2'h2, 14'h0000, 14'h0000, 32'h0, 8'h00, 2'h1};
    repeat (5) @(negedge i_clk);
    chk_reset();
    i_rst_b = 1'b1;
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      wc = ddrpi_mem_model_inst.wcount;
      rd_q.delete();
      ddrpi_mem_model_inst.act_row = 'x;
      ddrpi_mem_model_inst.rw_col = 'x;
      ddrpi_mem_model_inst.sel_n = 'x;
      if (rows[i].cmd.write) begin
        for (int k = 0; k < 4; k++) push(rows[i].base + k, rows[i].ben);
      end
      send_cmd(rows[i].cmd);
      chk("row addr", rows[i].cmd.row, ddrpi_mem_model_inst.act_row);
      chk("col addr", rows[i].cmd.col, ddrpi_mem_model_inst.rw_col);
      chk("act bank", rows[i].cmd.bank, ddrpi_mem_model_inst.act_bank);
      chk("rw bank", rows[i].cmd.bank, ddrpi_mem_model_inst.rw_bank);
      chk("chip sel", rows[i].cs_n, ddrpi_mem_model_inst.sel_n);
      chk("write en", !rows[i].cmd.write, ddrpi_mem_model_inst.rw_we_n);
      if (rows[i].cmd.write) begin
        chk("burst words", 4, ddrpi_mem_model_inst.wcount - wc);
        chk("byte mask", 8'(~rows[i].ben), ddrpi_mem_model_inst.last_mask);
        for (int k = 0; k < 4; k++) begin
          d = rows[i].base + k;
          for (int b = 0; b < 4; b++) if (rows[i].ben[b]) exp_mem[k][8*b+:8] = d[8*b+:8];
        end
      end else begin
        chk("read count", 4, rd_q.size());
        for (int k = 0; k < 4; k++) chk("read word", exp_mem[k], rd_q[k]);
      end
      $display("test row %0d done", i);
    end
    wc = ddrpi_mem_model_inst.wcount;
    n = 0;
    @(negedge i_clk);
    i_wr = {32'h0, 8'hFF};
    i_wr_valid = 1'b1;
    while (o_wr_ready === 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    i_wr_valid = 1'b0;
    chk("fifo room", `DDRPI_FIFO_DEPTH, n);
    for (int j = 0; j < 8; j++) send_cmd(rows[0].cmd);
    chk("drained words", 32, ddrpi_mem_model_inst.wcount - wc);
    chk("fifo ready", 1, o_wr_ready);
    $display("test fifo done");
    @(negedge i_clk);
    i_pwr_down = 1'b1;
    wait_cond(1, 100);
    chk("cke power-down", 0, o_mem_clk_en);
    @(negedge i_clk);
    i_pwr_down = 1'b0;
    wait_cond(2, 100);
    chk("cke normal", 1, o_mem_clk_en);
    $display("test power-down done");
    for (int k = 0; k < 4; k++) push(32'hFFFF_0000 + k, 8'hFF);
    @(negedge i_clk);
    i_cmd = rows[2].cmd;
    i_cmd_valid = 1'b1;
    wait_cond(0, 500);
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    wait_cond(3, 500);
    i_rst_b = 1'b0;
    @(negedge i_clk);
    chk_reset();
    i_rst_b = 1'b1;
    wait_cond(0, 500);
    chk("cke after reset", 1, o_mem_clk_en);
    $display("test mid-burst reset done");
    finish_test();
  end
endmodule

//--- shared/ddrpi_consts.svh
// constants of the ddr sdram pin interface: widths, counts, timing
// included by the package, the top module and the testbench
`ifndef DDRPI_CONSTS_SVH
`define DDRPI_CONSTS_SVH

`define DDRPI_ADDR_W      14
`define DDRPI_BANK_W      2
`define DDRPI_CS_W        2
`define DDRPI_DATA_W      32
`define DDRPI_LANES       4
`define DDRPI_MASK_W      8
`define DDRPI_CLK_COPIES  2
`define DDRPI_SW_OE_W     4
`define DDRPI_BURST_LEN   4
`define DDRPI_FIFO_DEPTH  32
`define DDRPI_CLK_NS      10
`define DDRPI_INIT_NS     200
`define DDRPI_INIT_CYC    ((`DDRPI_INIT_NS + `DDRPI_CLK_NS - 1) / `DDRPI_CLK_NS)

`endif

//--- shared/ddrpi_pkg.sv
// types of the ddr sdram pin interface: user command, write word, fsm states
// widths come from the constants header
package ddrpi_pkg;
  `include "ddrpi_consts.svh"

  typedef struct packed {
    logic                       write;
    logic                       chip;
    logic [`DDRPI_BANK_W-1:0]   bank;
    logic [`DDRPI_ADDR_W-1:0]   row;
    logic [`DDRPI_ADDR_W-1:0]   col;
  } ddrpi_cmd_s;

  typedef struct packed {
    logic [`DDRPI_DATA_W-1:0]   data;
    logic [`DDRPI_MASK_W-1:0]   byte_en;
  } ddrpi_wr_s;

  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_ACT, ST_RW, ST_DATA, ST_PDN
  } ddrpi_state_e;
endpackage

//--- verilog/ddrpi_fifo.sv
// write data fifo, width and depth as parameters, valid/ready both sides
// depth must be a power of two; ready and valid outputs are registered
`timescale 1ns/1ps
module ddrpi_fifo #(
  parameter int W     = 40,
  parameter int DEPTH = 32
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_in_valid,
  output logic                          o_in_ready,
  input  wire logic [W-1:0]             i_in_data,
  output logic                          o_out_valid,
  input  wire logic                     i_out_ready,
  output logic      [W-1:0]             o_out_data,
  output logic      [$clog2(DEPTH):0]   o_level
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          in_ready_ff;
  logic          out_valid_ff;

  wire           push      = i_in_valid & in_ready_ff;
  wire           pop       = i_out_ready & out_valid_ff;
  wire  [AW:0]   nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_ff    <= '0;
      rd_ptr_ff    <= '0;
      count_ff     <= '0;
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff    <= wr_ptr_ff + AW'(push);
      rd_ptr_ff    <= rd_ptr_ff + AW'(pop);
      count_ff     <= nxt_count;
      in_ready_ff  <= nxt_count != (AW+1)'(DEPTH);
      out_valid_ff <= nxt_count != '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  assign o_in_ready  = in_ready_ff;
  assign o_out_valid = out_valid_ff;
  assign o_out_data  = mem[rd_ptr_ff];
  assign o_level     = count_ff;
endmodule

//--- verilog/ddrpi_sync.sv
// two flip-flop synchroniser for a group of pin inputs
// assumes each bit is sampled independently; no bus coherence implied
`timescale 1ns/1ps
module ddrpi_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= i_async;
      stage2_ff <= stage1_ff;
    end
  end

  assign o_sync = stage2_ff;
endmodule

//--- verilog/ddrpi_top.sv
// ddr sdram pin interface: drives command, clock and data pins of ddr memory
// assumes a free-running memory reference clock on i_link_clk, far slower
// than i_clk; user command and write data arrive on i_clk
`timescale 1ns/1ps
`include "ddrpi_consts.svh"
module ddrpi_top #(
  parameter int BURST_LEN  = `DDRPI_BURST_LEN,
  parameter int FIFO_DEPTH = `DDRPI_FIFO_DEPTH
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_b,
  input  wire logic                              i_link_clk,
  input  wire logic                              i_pwr_down,
  input  wire logic                              i_cmd_valid,
  input  wire ddrpi_pkg::ddrpi_cmd_s             i_cmd,
  output logic                                   o_cmd_ready,
  input  wire logic                              i_wr_valid,
  input  wire ddrpi_pkg::ddrpi_wr_s              i_wr,
  output logic                                   o_wr_ready,
  output logic                                   o_rd_valid,
  output logic      [`DDRPI_DATA_W-1:0]          o_rd_data,
  output logic      [`DDRPI_ADDR_W-1:0]          o_mem_row_col_addr,
  output logic      [`DDRPI_BANK_W-1:0]          o_mem_bank_sel,
  output logic                                   o_mem_row_strobe_n,
  output logic                                   o_mem_col_strobe_n,
  output logic                                   o_mem_write_en_n,
  output logic                                   o_mem_clk_en,
  output logic      [`DDRPI_CLK_COPIES-1:0]      o_mem_clk_pos,
  output logic      [`DDRPI_CLK_COPIES-1:0]      o_mem_clk_neg,
  output logic      [`DDRPI_CS_W-1:0]            o_mem_chip_sel_n,
  input  wire logic [`DDRPI_DATA_W-1:0]          i_mem_data_bus,
  output logic      [`DDRPI_DATA_W-1:0]          o_mem_data_bus,
  output logic                                   o_mem_data_bus_oe_n,
  output logic      [`DDRPI_MASK_W-1:0]          o_mem_byte_mask,
  input  wire logic [`DDRPI_LANES-1:0]           i_mem_byte_strobe,
  output logic      [`DDRPI_LANES-1:0]           o_mem_byte_strobe,
  output logic                                   o_mem_byte_strobe_oe_n,
  output logic      [`DDRPI_SW_OE_W-1:0]         o_mem_switch_oe_n
);
  localparam int DW  = `DDRPI_DATA_W;
  localparam int NL  = `DDRPI_LANES;
  localparam int AW  = `DDRPI_ADDR_W;
  localparam int CSW = `DDRPI_CS_W;
  localparam int LW  = $clog2(FIFO_DEPTH) + 1;
  localparam int FW  = $bits(ddrpi_pkg::ddrpi_wr_s);

  // pin sampling
  logic [DW+NL:0] sync_out;
  ddrpi_sync #(.W(DW+NL+1)) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async ({i_link_clk, i_mem_byte_strobe, i_mem_data_bus}),
    .o_sync  (sync_out)
  );
  wire          s_clk  = sync_out[DW+NL];
  wire [NL-1:0] s_dqs  = sync_out[DW+NL-1:DW];
  wire [DW-1:0] s_data = sync_out[DW-1:0];

  logic          link_q_ff;
  logic [NL-1:0] dqs_q_ff;
  wire           link_rise = s_clk & ~link_q_ff;
  wire           link_fall = ~s_clk & link_q_ff;
  wire           link_edge = link_rise | link_fall;

  // state and command holding
  ddrpi_pkg::ddrpi_state_e state_ff;
  ddrpi_pkg::ddrpi_state_e nxt_state;
  ddrpi_pkg::ddrpi_cmd_s   cmd_ff;
  logic                    pend_ff;
  logic                    cmd_ready_ff;
  logic [7:0]              init_cnt_ff;
  logic [7:0]              burst_cnt_ff;

  // write data fifo
  ddrpi_pkg::ddrpi_wr_s    fifo_out;
  logic [LW-1:0]           fifo_level;
  logic                    fifo_valid;
  logic                    fifo_in_ready;
  logic                    pop;
  ddrpi_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (i_wr_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_wr),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (fifo_out),
    .o_level     (fifo_level)
  );

  wire take      = i_cmd_valid & cmd_ready_ff;
  wire init_done = init_cnt_ff >= 8'(`DDRPI_INIT_CYC);
  wire wr_ok     = !cmd_ff.write || (fifo_level >= LW'(BURST_LEN));
  wire go        = link_fall && state_ff == ddrpi_pkg::ST_IDLE && pend_ff
                   && !i_pwr_down && wr_ok;
  wire issue_rw  = link_fall && state_ff == ddrpi_pkg::ST_ACT;
  wire issue_nop = link_fall && !go && !issue_rw;
  wire in_data   = state_ff == ddrpi_pkg::ST_DATA;
  // one edge past the last word, so the last word still stands on the bus
  wire burst_end = in_data && link_edge && burst_cnt_ff == 8'(BURST_LEN);
  assign pop     = in_data && cmd_ff.write && link_edge && fifo_valid
                   && burst_cnt_ff < 8'(BURST_LEN);
  wire rd_win    = in_data && !cmd_ff.write;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ddrpi_pkg::ST_INIT: if (init_done) nxt_state = ddrpi_pkg::ST_IDLE;
      ddrpi_pkg::ST_IDLE: begin
        if (link_fall && i_pwr_down && !go) nxt_state = ddrpi_pkg::ST_PDN;
        else if (go) nxt_state = ddrpi_pkg::ST_ACT;
      end
      ddrpi_pkg::ST_ACT:  if (link_fall) nxt_state = ddrpi_pkg::ST_RW;
      ddrpi_pkg::ST_RW:   if (link_fall) nxt_state = ddrpi_pkg::ST_DATA;
      ddrpi_pkg::ST_DATA: if (burst_end) nxt_state = ddrpi_pkg::ST_IDLE;
      ddrpi_pkg::ST_PDN:  if (link_fall && !i_pwr_down) nxt_state = ddrpi_pkg::ST_IDLE;
      default:            nxt_state = ddrpi_pkg::ST_INIT;
    endcase
  end

  // command pin values; activate, read/write, else deselect
  wire [AW-1:0]  nxt_addr  = go ? cmd_ff.row : cmd_ff.col;
  wire [CSW-1:0] nxt_cs_n  = ~(CSW'(1) << cmd_ff.chip);
  wire           nxt_ras_n = !go;
  wire           nxt_cas_n = !issue_rw;
  wire           nxt_we_n  = !(issue_rw && cmd_ff.write);
  wire           nxt_cke   = nxt_state != ddrpi_pkg::ST_INIT
                             && nxt_state != ddrpi_pkg::ST_PDN;
  wire           nxt_drive = nxt_state == ddrpi_pkg::ST_DATA && cmd_ff.write;
  wire           nxt_ready = nxt_state == ddrpi_pkg::ST_IDLE && !pend_ff && !take;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff     <= ddrpi_pkg::ST_INIT;
      link_q_ff    <= 1'b0;
      dqs_q_ff     <= '0;
      init_cnt_ff  <= '0;
      burst_cnt_ff <= '0;
      pend_ff      <= 1'b0;
      cmd_ready_ff <= 1'b0;
      cmd_ff       <= '0;
    end else begin
      state_ff     <= nxt_state;
      link_q_ff    <= s_clk;
      dqs_q_ff     <= s_dqs;
      init_cnt_ff  <= init_done ? init_cnt_ff : init_cnt_ff + 8'h01;
      burst_cnt_ff <= !in_data ? 8'h00 : burst_cnt_ff + 8'(link_edge);
      pend_ff      <= take | (pend_ff & !go);
      cmd_ready_ff <= nxt_ready;
      if (take) cmd_ff <= i_cmd;
    end
  end

  // pin registers
  logic [AW-1:0]                      addr_ff;
  logic [`DDRPI_BANK_W-1:0]           bank_ff;
  logic                               ras_n_ff;
  logic                               cas_n_ff;
  logic                               we_n_ff;
  logic                               cke_ff;
  logic [CSW-1:0]                     cs_n_ff;
  logic [`DDRPI_CLK_COPIES-1:0]       ck_pos_ff;
  logic [`DDRPI_CLK_COPIES-1:0]       ck_neg_ff;
  logic [DW-1:0]                      dq_ff;
  logic                               dq_oe_n_ff;
  logic [`DDRPI_MASK_W-1:0]           mask_ff;
  logic [NL-1:0]                      dqs_ff;
  logic                               dqs_oe_n_ff;
  logic [`DDRPI_SW_OE_W-1:0]          sw_oe_n_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_ff  <= '0;
      bank_ff  <= '0;
      ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      we_n_ff  <= 1'b1;
      cs_n_ff  <= '1;
    end else if (go || issue_rw) begin
      addr_ff  <= nxt_addr;
      bank_ff  <= cmd_ff.bank;
      ras_n_ff <= nxt_ras_n;
      cas_n_ff <= nxt_cas_n;
      we_n_ff  <= nxt_we_n;
      cs_n_ff  <= nxt_cs_n;
    end else if (issue_nop) begin
      ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      we_n_ff  <= 1'b1;
      cs_n_ff  <= '1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cke_ff      <= 1'b0;
      ck_pos_ff   <= '0;
      ck_neg_ff   <= '1;
      dq_oe_n_ff  <= 1'b1;
      dqs_oe_n_ff <= 1'b1;
      sw_oe_n_ff  <= '1;
    end else begin
      cke_ff      <= nxt_cke;
      ck_pos_ff   <= {`DDRPI_CLK_COPIES{s_clk}};
      ck_neg_ff   <= {`DDRPI_CLK_COPIES{~s_clk}};
      dq_oe_n_ff  <= !nxt_drive;
      dqs_oe_n_ff <= !nxt_drive;
      sw_oe_n_ff  <= {`DDRPI_SW_OE_W{nxt_state != ddrpi_pkg::ST_DATA}};
    end
  end

  // write data: one word per link clock edge
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dq_ff   <= '0;
      mask_ff <= '1;
      dqs_ff  <= '0;
    end else if (pop) begin
      dq_ff   <= fifo_out.data;
      mask_ff <= ~fifo_out.byte_en;
      dqs_ff  <= ~dqs_ff;
    end else if (!nxt_drive) begin
      dqs_ff  <= '0;
      mask_ff <= '1;
    end
  end

  // read capture: each strobe edge latches its own byte lane
  logic [7:0]    rd_lane_ff [NL];
  logic          rd_valid_ff;
  wire  [NL-1:0] lane_edge = s_dqs ^ dqs_q_ff;

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++) begin : g_lane
      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          rd_lane_ff[gi] <= 8'h00;
        end else if (rd_win && lane_edge[gi]) begin
          rd_lane_ff[gi] <= s_data[8*gi +: 8];
        end
      end
      assign o_rd_data[8*gi +: 8] = rd_lane_ff[gi];
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) rd_valid_ff <= 1'b0;
    else rd_valid_ff <= rd_win && lane_edge[0];
  end

  assign o_cmd_ready            = cmd_ready_ff;
  assign o_wr_ready             = fifo_in_ready;
  assign o_rd_valid             = rd_valid_ff;
  assign o_mem_row_col_addr     = addr_ff;
  assign o_mem_bank_sel         = bank_ff;
  assign o_mem_row_strobe_n     = ras_n_ff;
  assign o_mem_col_strobe_n     = cas_n_ff;
  assign o_mem_write_en_n       = we_n_ff;
  assign o_mem_clk_en           = cke_ff;
  assign o_mem_clk_pos          = ck_pos_ff;
  assign o_mem_clk_neg          = ck_neg_ff;
  assign o_mem_chip_sel_n       = cs_n_ff;
  assign o_mem_data_bus         = dq_ff;
  assign o_mem_data_bus_oe_n    = dq_oe_n_ff;
  assign o_mem_byte_mask        = mask_ff;
  assign o_mem_byte_strobe      = dqs_ff;
  assign o_mem_byte_strobe_oe_n = dqs_oe_n_ff;
  assign o_mem_switch_oe_n      = sw_oe_n_ff;

  a_act_row_bank: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    go |=> !o_mem_row_strobe_n && o_mem_col_strobe_n
           && o_mem_row_col_addr == $past(cmd_ff.row) && o_mem_bank_sel == $past(cmd_ff.bank))
    else $error("activate pins wrong");
  a_rw_column: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    issue_rw |=> !o_mem_col_strobe_n && o_mem_row_strobe_n
                 && o_mem_row_col_addr == $past(cmd_ff.col))
    else $error("read/write pins wrong");
  a_write_enable: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    issue_rw |=> o_mem_write_en_n == !$past(cmd_ff.write))
    else $error("write enable wrong");
  a_chip_one_hot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    go |=> o_mem_chip_sel_n[$past(cmd_ff.chip)] == 1'b0 && $countones(o_mem_chip_sel_n) == 1)
    else $error("chip select wrong");
  a_cke_low_idle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_ff == ddrpi_pkg::ST_INIT || state_ff == ddrpi_pkg::ST_PDN) |-> !o_mem_clk_en)
    else $error("clock enable high in init or power-down");
  a_cke_high_run: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (state_ff == ddrpi_pkg::ST_ACT || in_data) |-> o_mem_clk_en)
    else $error("clock enable low while running");
  a_clk_pairs: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_mem_clk_pos == ~o_mem_clk_neg && o_mem_clk_pos[0] == o_mem_clk_pos[1])
    else $error("clock pair mismatch");
  a_mask_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    pop |=> o_mem_byte_mask == ~$past(fifo_out.byte_en))
    else $error("mask polarity wrong");
  a_drive_dir: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rd_win |-> o_mem_data_bus_oe_n && o_mem_byte_strobe_oe_n)
    else $error("bus driven during read");
  a_burst_ends: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(in_data) |-> ##[1:100] !in_data)
    else $error("data phase too long");
endmodule
